/* File: design/scr_pkg.sv */
// scr_pkg: register map, field layout, reset values and carriers for the
// converter system control register slice.
// assumes a classic wishbone master with 32-bit data on the same clock.
package scr_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_SYSTEM_CONTROL = 8'h09;
  localparam logic [7:0] IDX_RESERVED_0A = 8'h0a;
  localparam logic [7:0] IDX_OFFSET_LOW = 8'h0b;
  localparam logic [7:0] IDX_OFFSET_HIGH = 8'h0c;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 8;

  // reset values
  localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h10;
  localparam logic [7:0] RST_RESERVED_0A = 8'h00;
  localparam logic [7:0] RST_OFFSET_LOW = 8'h00;
  localparam logic [7:0] RST_OFFSET_HIGH = 8'h00;

  // system control field positions
  localparam int POS_MON_HI = 7;
  localparam int POS_MON_LO = 5;
  localparam int POS_AVG_HI = 4;
  localparam int POS_AVG_LO = 3;
  localparam int POS_TIMEOUT = 2;
  localparam int POS_CRC = 1;
  localparam int POS_STATUS = 0;

  // monitor select codes
  typedef enum logic [2:0] {
    SCR_MON_OFF = 3'b000,
    SCR_MON_MIDSUPPLY = 3'b001,
    SCR_MON_TEMP = 3'b010,
    SCR_MON_ANALOG_SUPPLY = 3'b011,
    SCR_MON_DIGITAL_SUPPLY = 3'b100,
    SCR_MON_BURNOUT_LOW = 3'b101,
    SCR_MON_BURNOUT_MID = 3'b110,
    SCR_MON_BURNOUT_HIGH = 3'b111
  } scr_mon_t;

  // burn-out current selection, one-hot: 0.2 ua, 1 ua, 10 ua
  localparam logic [2:0] BURN_NONE = 3'b000;
  localparam logic [2:0] BURN_0P2_UA = 3'b001;
  localparam logic [2:0] BURN_1_UA = 3'b010;
  localparam logic [2:0] BURN_10_UA = 3'b100;

  // calibration sample counts for codes 00..11
  localparam logic [4:0] CAL_SAMPLES_0 = 5'h01;
  localparam logic [4:0] CAL_SAMPLES_1 = 5'h04;
  localparam logic [4:0] CAL_SAMPLES_2 = 5'h08;
  localparam logic [4:0] CAL_SAMPLES_3 = 5'h10;

  // amplifier enable code required for the temperature measurement
  localparam logic [1:0] AMP_EN_TEMP = 2'b01;
  localparam logic [2:0] GAIN_UNITY = 3'h0; // gain field code for x1

  // decoded analog control carried to the front end
  typedef struct packed {
    logic inputs_shorted;   // amplifier inputs at mid-supply
    logic temp_sensor;      // temperature sensor routed
    logic analog_supply;    // analog supply difference / 4
    logic digital_supply;   // digital supply / 4
    logic mux_open;         // input multiplexer switches open
    logic [2:0] burnout;    // one-hot burn-out current
    logic [2:0] eff_gain;   // gain code actually applied
    logic temp_misconfig;   // temperature chosen without amplifier enabled
  } scr_analog_t;

  // framing controls carried to the serial output path
  typedef struct packed {
    logic timeout_en;
    logic crc_en;
    logic status_en;
    logic [4:0] cal_samples;
  } scr_frame_t;

endpackage : scr_pkg

/* File: design/scr_reg8.sv */
// scr_reg8: one eight-bit software register with reset value and write enable.
// assumes the caller qualifies the write with the bus handshake.
module scr_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input wire logic ref_clk,     // device clock
  input wire logic resetn,      // async reset, active low
  input wire logic clk_en,      // freezes the register while low
  input wire logic wr,          // write strobe
  input wire logic [7:0] wdata, // write data
  output logic [7:0] q          // held value
);

  // hold last written value, reset to the documented default
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      q <= RESET_VALUE;
    else if (clk_en && wr)
      q <= wdata;
  end

endmodule : scr_reg8

/* File: design/scr_regs.sv */
// scr_regs: system control, reserved and offset calibration registers with
// decode of the monitor, averaging and framing controls.
// assumes a classic wishbone master on ref_clk; the serial framing, crc
// engine and analog front end sit outside and consume the decoded outputs.
// Contract
// R01: monitor 000 off; 001 shorts inputs mid-supply
// R02: monitor 010 routes temperature sensor, amplifier on
// R03: host keeps gain four or less for temperature
// R04: 011 analog supply/4, 100 digital supply/4
// R05: supply monitors force effective gain to one
// R06: 101,110,111 give 0.2, 1, 10 ua burn-out
// R07: mux switches open for shorted, temp, supply
// R08: averaging field sets calibration sample count
// R09: averaging codes give 1,4,8,16; reset eight
// R10: bit 2 enables serial timeout, reset off
// R11: bit 1 appends check byte, reset off
// R12: check byte covers result and status byte
// R13: bit 0 prefixes status byte, reset off
// R14: register 0ah reserved, reads 00h, host writes 00h
// R15: register 0bh holds offset low byte, reset 00h
// R16: system control at 09h, resets to 10h
// R17: register 0ch holds offset high byte, reset 00h
// R18: read-write fields read back last written value
//
// The Wishbone register port was left to the implementer.
module scr_regs (
  input wire logic ref_clk,             // device clock, 40 mhz
  input wire logic resetn,              // async reset, active low
  input wire logic clk_en,              // freezes all state while low
  input wire logic wb_cyc_i,            // wishbone cycle
  input wire logic wb_stb_i,            // wishbone strobe
  input wire logic wb_we_i,             // wishbone write
  input wire logic [31:0] wb_adr_i,     // byte address
  input wire logic [31:0] wb_dat_i,     // write data
  input wire logic [3:0] wb_sel_i,      // byte lane selects
  output logic [31:0] wb_dat_o,         // read data, registered
  output logic wb_ack_o,                // acknowledge, registered
  output logic wb_err_o,                // error on unmapped address
  input wire logic [2:0] gain_setting,  // user gain code from the gain field
  input wire logic [1:0] amplifier_enable, // amplifier enable code
  output scr_pkg::scr_analog_t analog_ctrl, // decoded analog controls
  output scr_pkg::scr_frame_t frame_ctrl,   // serial framing controls
  output logic [15:0] offset_correction     // sixteen-bit offset value
);

  logic req;
  logic [scr_pkg::IDX_W-1:0] idx;
  logic hit_sys;
  logic hit_rsv;
  logic hit_ofl;
  logic hit_ofh;
  logic mapped;
  logic wr_lane0;
  logic [7:0] system_control;
  logic [7:0] offset_correction_low;
  logic [7:0] offset_correction_high;
  logic [7:0] next_rdata;
  scr_pkg::scr_mon_t monitor_select;
  logic [1:0] calibration_average_count;
  scr_pkg::scr_analog_t next_analog;
  scr_pkg::scr_frame_t next_frame;

  // decode; a new request only while ack is low so each cycle answers once
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign idx = wb_adr_i[scr_pkg::ADDR_LSB +: scr_pkg::IDX_W];
  assign mapped = (wb_adr_i[31:scr_pkg::ADDR_LSB+scr_pkg::IDX_W] == '0)
    && (wb_adr_i[scr_pkg::ADDR_LSB-1:0] == 2'h0);
  assign hit_sys = mapped && (idx == scr_pkg::IDX_SYSTEM_CONTROL);
  assign hit_rsv = mapped && (idx == scr_pkg::IDX_RESERVED_0A);
  assign hit_ofl = mapped && (idx == scr_pkg::IDX_OFFSET_LOW);
  assign hit_ofh = mapped && (idx == scr_pkg::IDX_OFFSET_HIGH);
  // only the low lane carries register data; upper lanes are ignored
  assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

  // system control register at 09h, reset 10h [R16]
  scr_reg8 #(
    .RESET_VALUE(scr_pkg::RST_SYSTEM_CONTROL)
  ) u_system_control (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .wr(wr_lane0 && hit_sys),
    .wdata(wb_dat_i[7:0]),
    .q(system_control)
  );

  // offset calibration low byte at 0bh [R15]
  scr_reg8 #(
    .RESET_VALUE(scr_pkg::RST_OFFSET_LOW)
  ) u_offset_low (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .wr(wr_lane0 && hit_ofl),
    .wdata(wb_dat_i[7:0]),
    .q(offset_correction_low)
  );

  // offset calibration high byte at 0ch [R17]
  scr_reg8 #(
    .RESET_VALUE(scr_pkg::RST_OFFSET_HIGH)
  ) u_offset_high (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .wr(wr_lane0 && hit_ofh),
    .wdata(wb_dat_i[7:0]),
    .q(offset_correction_high)
  );

  // field extraction
  assign monitor_select =
    scr_pkg::scr_mon_t'(system_control[scr_pkg::POS_MON_HI:scr_pkg::POS_MON_LO]);
  assign calibration_average_count =
    system_control[scr_pkg::POS_AVG_HI:scr_pkg::POS_AVG_LO];

  // read mux; the reserved register has no storage and always reads 00h
  always_comb
  begin
    next_rdata = 8'h00;
    if (hit_sys)
      next_rdata = system_control; // [R18]
    else if (hit_rsv)
      next_rdata = scr_pkg::RST_RESERVED_0A; // [R14]
    else if (hit_ofl)
      next_rdata = offset_correction_low; // [R18]
    else if (hit_ofh)
      next_rdata = offset_correction_high; // [R17]
  end

  // bus answer one cycle after the request; writes to 0ah are dropped
  // silently, which keeps host code that writes 00h there harmless
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      wb_ack_o <= req && (hit_sys || hit_rsv || hit_ofl || hit_ofh);
      wb_err_o <= req && !(hit_sys || hit_rsv || hit_ofl || hit_ofh);
      if (req && !wb_we_i)
        wb_dat_o <= {24'h00_0000, next_rdata};
    end
  end

  // monitor decode into analog front-end controls
  always_comb
  begin
    next_analog = '0;
    next_analog.eff_gain = gain_setting;
    case (monitor_select)
      scr_pkg::SCR_MON_OFF:
      begin
        next_analog.mux_open = 1'b0; // [R01]
      end
      scr_pkg::SCR_MON_MIDSUPPLY:
      begin
        next_analog.inputs_shorted = 1'b1; // [R01]
        next_analog.mux_open = 1'b1; // [R07]
      end
      scr_pkg::SCR_MON_TEMP:
      begin
        next_analog.temp_sensor = 1'b1; // [R02]
        next_analog.mux_open = 1'b1; // [R07]
        // flag only; the gain limit of four is left to the host [R03]
        next_analog.temp_misconfig =
          (amplifier_enable != scr_pkg::AMP_EN_TEMP); // [R02]
      end
      scr_pkg::SCR_MON_ANALOG_SUPPLY:
      begin
        next_analog.analog_supply = 1'b1; // [R04]
        next_analog.mux_open = 1'b1; // [R07]
        next_analog.eff_gain = scr_pkg::GAIN_UNITY; // [R05]
      end
      scr_pkg::SCR_MON_DIGITAL_SUPPLY:
      begin
        next_analog.digital_supply = 1'b1; // [R04]
        next_analog.mux_open = 1'b1; // [R07]
        next_analog.eff_gain = scr_pkg::GAIN_UNITY; // [R05]
      end
      scr_pkg::SCR_MON_BURNOUT_LOW:
        next_analog.burnout = scr_pkg::BURN_0P2_UA; // [R06]
      scr_pkg::SCR_MON_BURNOUT_MID:
        next_analog.burnout = scr_pkg::BURN_1_UA; // [R06]
      scr_pkg::SCR_MON_BURNOUT_HIGH:
        next_analog.burnout = scr_pkg::BURN_10_UA; // [R06]
      default:
        next_analog.burnout = scr_pkg::BURN_NONE;
    endcase
  end

  // framing controls and calibration sample count
  always_comb
  begin
    next_frame = '0;
    next_frame.timeout_en = system_control[scr_pkg::POS_TIMEOUT]; // [R10]
    // the crc engine downstream covers result plus status when both set
    next_frame.crc_en = system_control[scr_pkg::POS_CRC]; // [R11] [R12]
    next_frame.status_en = system_control[scr_pkg::POS_STATUS]; // [R13]
    case (calibration_average_count)
      2'h0: next_frame.cal_samples = scr_pkg::CAL_SAMPLES_0; // [R09]
      2'h1: next_frame.cal_samples = scr_pkg::CAL_SAMPLES_1; // [R09]
      2'h2: next_frame.cal_samples = scr_pkg::CAL_SAMPLES_2; // [R08]
      2'h3: next_frame.cal_samples = scr_pkg::CAL_SAMPLES_3; // [R08]
      default: next_frame.cal_samples = scr_pkg::CAL_SAMPLES_2;
    endcase
  end

  // outputs registered: one cycle behind the register contents
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      analog_ctrl <= '0;
      frame_ctrl <= '0;
      offset_correction <= 16'h0000;
    end
    else if (clk_en)
    begin
      analog_ctrl <= next_analog;
      frame_ctrl <= next_frame;
      offset_correction <= {offset_correction_high,
        offset_correction_low}; // [R17]
    end
  end

  // supply monitors always show unity gain one cycle later
  a_unity_gain: assert property ( // [R05]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && (monitor_select == scr_pkg::SCR_MON_ANALOG_SUPPLY ||
    monitor_select == scr_pkg::SCR_MON_DIGITAL_SUPPLY)
    |=> analog_ctrl.eff_gain == scr_pkg::GAIN_UNITY)
    else $error("supply monitor gain not unity");

  // input switches open exactly for shorted, temperature and supply codes
  a_mux_open: assert property ( // [R07]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en |=> analog_ctrl.mux_open == ($past(monitor_select) inside {
    scr_pkg::SCR_MON_MIDSUPPLY, scr_pkg::SCR_MON_TEMP,
    scr_pkg::SCR_MON_ANALOG_SUPPLY, scr_pkg::SCR_MON_DIGITAL_SUPPLY}))
    else $error("mux switch state wrong for monitor code");

  // highest burn-out code selects the largest current source
  a_burnout_code: assert property ( // [R06]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && monitor_select == scr_pkg::SCR_MON_BURNOUT_HIGH
    |=> analog_ctrl.burnout == scr_pkg::BURN_10_UA)
    else $error("burn-out current not at high setting");

  // temperature code routes the sensor, inputs not shorted
  a_temp_route: assert property ( // [R02]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && monitor_select == scr_pkg::SCR_MON_TEMP
    |=> analog_ctrl.temp_sensor && !analog_ctrl.inputs_shorted)
    else $error("temperature sensor not routed");

  // monitor off releases every analog control except eff_gain, which carries gain_setting; the reset release edge is
  // skipped since the outputs are still cleared at the edge after it
  a_mon_off: assert property ( // [R01]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && resetn && monitor_select == scr_pkg::SCR_MON_OFF
    |=> !analog_ctrl.mux_open && !analog_ctrl.inputs_shorted &&
    !analog_ctrl.temp_sensor && !analog_ctrl.analog_supply &&
    !analog_ctrl.digital_supply &&
    analog_ctrl.burnout == scr_pkg::BURN_NONE &&
    analog_ctrl.eff_gain == $past(gain_setting))
    else $error("monitor off still drives analog controls");

  // largest averaging code selects sixteen samples
  a_avg_count: assert property ( // [R09]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && calibration_average_count == 2'h3
    |=> frame_ctrl.cal_samples == scr_pkg::CAL_SAMPLES_3)
    else $error("sixteen-sample averaging not selected");

  // framing enables copy their register bits one cycle later
  a_frame_bits: assert property ( // [R10] [R11] [R13]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en |=>
    frame_ctrl.timeout_en == $past(system_control[scr_pkg::POS_TIMEOUT]) &&
    frame_ctrl.crc_en == $past(system_control[scr_pkg::POS_CRC]) &&
    frame_ctrl.status_en == $past(system_control[scr_pkg::POS_STATUS]))
    else $error("framing controls do not follow register");

  // reserved register has no storage and answers zero
  a_rsv_read: assert property ( // [R14]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && req && !wb_we_i && hit_rsv
    |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("reserved register read nonzero");

  // offset low byte takes a lane-0 write at the taking edge
  a_write_back: assert property ( // [R15]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && wr_lane0 && hit_ofl
    |=> offset_correction_low == $past(wb_dat_i[7:0]))
    else $error("offset low byte did not take write");

  // system control reads back its held value
  a_sys_read: assert property ( // [R18]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && req && !wb_we_i && hit_sys
    |=> wb_ack_o && wb_dat_o[7:0] == $past(system_control))
    else $error("system control readback mismatch");

  // offset high byte reads back its held value
  a_ofh_read: assert property ( // [R17]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && req && !wb_we_i && hit_ofh
    |=> wb_ack_o && wb_dat_o[7:0] == $past(offset_correction_high))
    else $error("offset high byte readback mismatch");

  // one answer per request: ack is a single-cycle pulse
  a_ack_drop: assert property ( // [R18]
    @(posedge ref_clk) disable iff (!resetn)
    clk_en && wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

endmodule : scr_regs

/* File: testbench/scr_host_model.sv */
// scr_host_model: host controller stand-in that speaks classic wishbone
// and drives the amplifier settings the block reads.
// assumes the block answers each request with ack or err on ref_clk.
module scr_host_model (
  input wire logic ref_clk, // device clock
  output logic wb_cyc, // cycle
  output logic wb_stb, // strobe
  output logic wb_we, // write
  output logic [31:0] wb_adr, // byte address
  output logic [31:0] wb_dat, // write data
  output logic [3:0] wb_sel, // lane selects
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack, // acknowledge
  input wire logic wb_err, // error
  output logic [2:0] gain_setting, // user gain code
  output logic [1:0] amplifier_enable // amplifier enable code
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus and a legal front end from time zero
  initial
  begin
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 32'h0;
    wb_dat = 32'h0;
    wb_sel = 4'h0;
    gain_setting = 3'h0;
    amplifier_enable = 2'b01;
  end

  // one classic cycle; waits for ack or err, only the bench watchdog
  // ends a wait on a dead slave
  task automatic bus(input logic we, input logic [7:0] idx,
    input logic [7:0] wd, output logic [7:0] rd, output logic er);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= 4'h1;
    wb_adr <= {22'h0, idx, 2'b00};
    wb_dat <= {24'h0, (idx == 8'h0a) ? 8'h00 : wd};
    do
      @(posedge ref_clk);
    while (wb_ack !== 1'b1 && wb_err !== 1'b1);
    rd = wb_dat_o[7:0];
    er = wb_err;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus

  // temperature reads keep the gain at four or less
  task automatic set_front(input logic [2:0] mon, input logic amp_on);
    @(posedge ref_clk);
    amplifier_enable <= amp_on ? 2'b01 : 2'b00;
    gain_setting <= (mon == 3'b010) ? 3'h2 : 3'h5;
  endtask : set_front
endmodule : scr_host_model

/* File: testbench/adc_system_control_regs_bench.sv */
// adc_system_control_regs_bench: self-checking bench for scr_regs.
// assumes scr_host_model provides the bus and front-end drive.
module adc_system_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic wb_cyc, wb_stb, wb_we, wb_ack, wb_err;
  logic [31:0] wb_adr, wb_dat, wb_dat_o;
  logic [3:0] wb_sel;
  logic [2:0] gain_setting;
  logic [1:0] amplifier_enable;
  scr_pkg::scr_analog_t analog_ctrl;
  scr_pkg::scr_frame_t frame_ctrl;
  logic [15:0] offset_correction;
  logic [7:0] rd;
  logic er;
  int n_errors = 0;
  int check_count = 0;

  // 40 mhz device clock
  always #12.5 ref_clk = ~ref_clk;

  scr_regs scr_regs_inst (.ref_clk(ref_clk), .resetn(resetn),
    .clk_en(clk_en), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .wb_err_o(wb_err),
    .gain_setting(gain_setting), .amplifier_enable(amplifier_enable),
    .analog_ctrl(analog_ctrl), .frame_ctrl(frame_ctrl),
    .offset_correction(offset_correction));

  scr_host_model scr_host_model_inst (.ref_clk(ref_clk), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat(wb_dat),
    .wb_sel(wb_sel), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .wb_err(wb_err),
    .gain_setting(gain_setting), .amplifier_enable(amplifier_enable));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic acc(input logic we, input logic [7:0] idx,
    input logic [7:0] wd);
    scr_host_model_inst.bus(we, idx, wd, rd, er);
  endtask : acc

  // outputs follow the registers one edge after the ack
  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic t_reset_values;
    acc(1'b0, 8'h09, 8'h00);
    chk(rd, 8'h10, "sysctl reset");
    acc(1'b0, 8'h0a, 8'h00);
    chk(rd, 8'h00, "reserved reset");
    acc(1'b0, 8'h0b, 8'h00);
    chk(rd, 8'h00, "offset low reset");
    acc(1'b0, 8'h0c, 8'h00);
    chk(rd, 8'h00, "offset high reset");
    chk(32'(frame_ctrl), 32'h08, "frame reset");
  endtask : t_reset_values

  task automatic t_averaging;
    logic [4:0] n_s [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
    for (int c = 0; c < 4; c++)
    begin
      acc(1'b1, 8'h09, {3'b000, 2'(c), 3'b000});
      settle();
      chk(32'(frame_ctrl.cal_samples), 32'(n_s[c]), "samples");
    end
  endtask : t_averaging

  task automatic t_framing;
    for (int i = 0; i < 4; i++)
    begin
      acc(1'b1, 8'h09, (i == 3) ? 8'h17 : (8'h10 | 8'(1 << i)));
      settle();
      chk(frame_ctrl.timeout_en, i == 2 || i == 3, "timeout");
      chk(frame_ctrl.crc_en, i == 1 || i == 3, "crc");
      chk(frame_ctrl.status_en, i == 0 || i == 3, "status");
    end
    acc(1'b0, 8'h09, 8'h00);
    chk(rd, 8'h17, "sysctl readback");
  endtask : t_framing

  task automatic t_monitor(input logic amp_on);
    scr_pkg::scr_analog_t e;
    logic [2:0] g;
    for (int c = 0; c < 8; c++)
    begin
      scr_host_model_inst.set_front(3'(c), amp_on);
      g = (c == 2) ? 3'h2 : 3'h5;
      acc(1'b1, 8'h09, {3'(c), 5'h10});
      settle();
      e = '0;
      e.inputs_shorted = (c == 1);
      e.temp_sensor = (c == 2);
      e.analog_supply = (c == 3);
      e.digital_supply = (c == 4);
      e.mux_open = (c >= 1 && c <= 4);
      e.burnout = (c == 5) ? scr_pkg::BURN_0P2_UA : (c == 6) ?
        scr_pkg::BURN_1_UA : (c == 7) ? scr_pkg::BURN_10_UA :
        scr_pkg::BURN_NONE;
      e.eff_gain = (c == 3 || c == 4) ? scr_pkg::GAIN_UNITY : g;
      e.temp_misconfig = (c == 2) && !amp_on;
      chk(32'(analog_ctrl), 32'(e), "monitor");
    end
  endtask : t_monitor

  task automatic t_offset;
    acc(1'b1, 8'h0b, 8'ha5);
    acc(1'b1, 8'h0c, 8'h3c);
    acc(1'b1, 8'h0a, 8'h00);
    settle();
    chk(offset_correction, 16'h3ca5, "offset value");
    acc(1'b0, 8'h0b, 8'h00);
    chk(rd, 8'ha5, "offset low readback");
    acc(1'b0, 8'h0c, 8'h00);
    chk(rd, 8'h3c, "offset high readback");
    acc(1'b0, 8'h0a, 8'h00);
    chk(rd, 8'h00, "reserved reads zero");
    acc(1'b1, 8'h0d, 8'h55);
    chk(er, 1'b1, "unmapped write refused");
  endtask : t_offset

  // clock enable low holds a pending write until it rises again
  task automatic t_freeze;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    fork
      acc(1'b1, 8'h0b, 8'h5a);
      begin
        repeat (4) @(posedge ref_clk);
        chk(wb_ack, 1'b0, "no answer while frozen");
        chk(offset_correction, 16'h3ca5, "frozen offset");
        clk_en <= 1'b1;
      end
    join
    acc(1'b0, 8'h0b, 8'h00);
    chk(rd, 8'h5a, "offset low after freeze");
  endtask : t_freeze

  task automatic t_mid_reset;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    acc(1'b0, 8'h09, 8'h00);
    chk(rd, 8'h10, "sysctl after reset");
    acc(1'b0, 8'h0b, 8'h00);
    chk(rd, 8'h00, "offset after reset");
  endtask : t_mid_reset

  // watchdog: the whole sequence needs well under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    stop_test();
  end

  // main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset_values();
    t_averaging();
    t_framing();
    t_monitor(1'b1);
    t_monitor(1'b0);
    t_offset();
    t_freeze();
    t_mid_reset();
    stop_test();
  end
endmodule : adc_system_control_regs_bench
